// >>> ivf_fault_responder.sv
// One fault response sequencer: decides whether the output may run.
// Assumes the fault level is already registered and clear is a one-cycle pulse.
module ivf_fault_responder (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Fault and settings in, run permission out
  ivf_resp_if.resp    port
);
  ivf_pkg::ivf_resp_state_t state;
  ivf_pkg::ivf_resp_state_t next_state;
  logic [2:0]  attempts;
  logic [2:0]  next_attempts;
  logic [15:0] pre_cnt;
  logic [7:0]  unit_cnt;

  wire logic [1:0] resp_code  = port.action[ivf_pkg::RESP_HI:ivf_pkg::RESP_LO];
  wire logic [2:0] retries    = port.action[ivf_pkg::RETRY_HI:ivf_pkg::RETRY_LO];
  wire logic [2:0] delay_code = port.action[ivf_pkg::DELAY_HI:ivf_pkg::DELAY_LO];
  // A unit length of zero is taken as one cycle so the timer always ends
  wire logic pre_last   = (port.unit_cycles == 16'h0000) || (pre_cnt == port.unit_cycles - 16'h0001); // R8
  wire logic unit_last  = (unit_cnt == ivf_pkg::ivf_delay_units(delay_code) - 8'h01); // R6
  wire logic timer_done = pre_last && unit_last;
  wire logic timer_load = (next_state != state);
  wire logic no_retry   = (retries == 3'h0);

  always_comb begin
    next_state    = state;
    next_attempts = attempts;
    case (state)
      ivf_pkg::ST_RUN: begin
        if (port.fault) begin
          if (resp_code == ivf_pkg::RESP_DELAY_THEN) begin
            next_state = ivf_pkg::ST_DELAY; // R2
          end else if (resp_code == ivf_pkg::RESP_DISABLE_RETRY) begin
            next_attempts = retries; // R15
            next_state    = no_retry ? ivf_pkg::ST_LATCH : ivf_pkg::ST_WAIT; // R3
          end else if (resp_code == ivf_pkg::RESP_RESUME_WHEN_OK) begin
            next_state = ivf_pkg::ST_HOLD; // R4
          end
        end
      end
      ivf_pkg::ST_DELAY: begin
        if (!port.fault) begin
          next_state = ivf_pkg::ST_RUN;
        end else if (timer_done) begin
          next_attempts = retries; // R7
          next_state    = no_retry ? ivf_pkg::ST_LATCH : ivf_pkg::ST_WAIT; // R2
        end
      end
      ivf_pkg::ST_WAIT: begin
        if (timer_done) begin
          next_attempts = attempts - 3'h1; // R15
          next_state    = ivf_pkg::ST_TRY; // R7
        end
      end
      ivf_pkg::ST_TRY: begin
        if (port.fault) begin
          next_state = (attempts == 3'h0) ? ivf_pkg::ST_LATCH : ivf_pkg::ST_WAIT; // R15
        end else if (timer_done) begin
          next_state = ivf_pkg::ST_RUN;
        end
      end
      ivf_pkg::ST_HOLD: begin
        if (!port.fault) begin
          next_state = ivf_pkg::ST_RUN; // R4
        end
      end
      ivf_pkg::ST_LATCH: begin
        if (port.clear) begin
          next_state = ivf_pkg::ST_RUN; // R5
        end
      end
      default: next_state = ivf_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= ivf_pkg::ST_RUN;
      attempts     <= 3'h0;
      port.run     <= 1'b1;
      port.latched <= 1'b0;
    end else begin
      state        <= next_state;
      attempts     <= next_attempts;
      // Ignore code never leaves ST_RUN, so the output is never interrupted
      port.run     <= (next_state == ivf_pkg::ST_RUN) || (next_state == ivf_pkg::ST_DELAY) ||
                      (next_state == ivf_pkg::ST_TRY); // R1
      port.latched <= (next_state == ivf_pkg::ST_LATCH);
    end
  end

  // Delay timer restarts on every state change
  always_ff @(posedge clk) begin
    if (rst || timer_load) begin
      pre_cnt  <= 16'h0000;
      unit_cnt <= 8'h00;
    end else if (pre_last) begin
      pre_cnt  <= 16'h0000;
      unit_cnt <= unit_cnt + 8'h01;
    end else begin
      pre_cnt  <= pre_cnt + 16'h0001;
    end
  end
endmodule

// >>> ivf_host_model.sv
// Host model for the management link: byte and word register writes.
// Assumes the bench resolves sda as open drain with a pull-up.
module ivf_host_model (
  // Link pins
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // 200 ns a bit; the device answers about 60 ns after scl falls, well inside the low phase
  localparam int HALF = 100;
  logic ack;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic seen);
    #(HALF/2) sda_low = !b;
    #(HALF/2) scl = 1'b1;
    #HALF seen = sda;
    scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ok = !s;
  endtask
  task automatic write(input logic [7:0] cmd, input logic [15:0] v, input int n);
    logic a0, a1, a2, a3;
    #HALF sda_low = 1'b1;
    #HALF scl = 1'b0;
    send({ivf_pkg::SLAVE_ADDR, 1'b0}, a0);
    send(cmd, a1);
    send(v[7:0], a2);
    a3 = 1'b1;
    if (n == 2) send(v[15:8], a3);
    #(HALF/2) sda_low = 1'b1;
    #(HALF/2) scl = 1'b1;
    #HALF sda_low = 1'b0;
    ack = a0 && a1 && a2 && a3;
  endtask
endmodule

// >>> ivf_pkg.sv
// Shared constants, types and helpers for the input voltage fault supervisor.
// Assumes one clock domain; management link pins are synchronised in the top.
package ivf_pkg;

  // Command codes of the registers held here
  localparam logic [7:0] CMD_OV_FAULT_ACTION = 8'h56;
  localparam logic [7:0] CMD_OV_WARN_THRESH  = 8'h57;
  localparam logic [7:0] CMD_UV_WARN_THRESH  = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT_THRESH = 8'h59;
  localparam logic [7:0] CMD_UV_FAULT_ACTION = 8'h5a;
  // Neighbouring settings that arrive on ports instead of registers
  localparam logic [7:0] CMD_DELAY_TIME_UNIT = 8'hd2;
  localparam logic [7:0] CMD_VENDOR_OPTIONS  = 8'he0;

  // Reset values
  localparam logic [7:0]  RST_OV_FAULT_ACTION = 8'h80;
  localparam logic [7:0]  RST_UV_FAULT_ACTION = 8'hc0;
  localparam logic [15:0] RST_OV_WARN_THRESH  = 16'h03ff;
  localparam logic [15:0] RST_UV_WARN_THRESH  = 16'h0000;
  localparam logic [15:0] RST_UV_FAULT_THRESH = 16'h0000;

  // Fault action field positions
  localparam int RESP_HI  = 7;
  localparam int RESP_LO  = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  // Response codes
  localparam logic [1:0] RESP_IGNORE        = 2'h0;
  localparam logic [1:0] RESP_DELAY_THEN    = 2'h1;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] RESP_RESUME_WHEN_OK = 2'h3;

  // Vendor option bit that enables the ratio regulation mode
  localparam int VOPT_RATIO_BIT = 0;

  // Status bit positions
  localparam int STAT_OV_WARN    = 0;
  localparam int STAT_UV_WARN    = 1;
  localparam int STAT_OV_FAULT   = 2;
  localparam int STAT_UV_FAULT   = 3;
  localparam int STAT_OV_LATCHED = 4;
  localparam int STAT_UV_LATCHED = 5;

  // Management link slave address (arbitrary)
  localparam logic [6:0] SLAVE_ADDR = 7'h10;

  typedef enum logic [2:0] {SMB_IDLE, SMB_RX, SMB_RACK, SMB_TX, SMB_TACK, SMB_TNEXT} ivf_smb_state_t;
  typedef enum logic [2:0] {ST_RUN, ST_DELAY, ST_WAIT, ST_TRY, ST_HOLD, ST_LATCH} ivf_resp_state_t;

  // Linear format (5-bit exponent, 11-bit mantissa) scaled by 2^16 to a fixed-point value
  function automatic logic signed [42:0] ivf_lin_value(input logic [15:0] v);
    logic signed [42:0] m;
    logic [4:0]         sh;
    m  = {{32{v[10]}}, v[10:0]};
    sh = v[15:11] + 5'h10;
    return m <<< sh;
  endfunction

  // Delay code n gives 2^n time units
  function automatic logic [7:0] ivf_delay_units(input logic [2:0] code);
    return 8'h01 << code;
  endfunction

  // Data bytes that a command carries: 0 unsupported, 1 byte, 2 word
  function automatic logic [1:0] ivf_cmd_width(input logic [7:0] code);
    if (code == CMD_OV_FAULT_ACTION || code == CMD_UV_FAULT_ACTION)
      return 2'h1;
    if (code == CMD_OV_WARN_THRESH || code == CMD_UV_WARN_THRESH || code == CMD_UV_FAULT_THRESH)
      return 2'h2;
    return 2'h0;
  endfunction

endpackage

// >>> ivf_resp_if.sv
// Connection between the supervisor top and one fault responder.
// Assumes both ends run on the same clock.
interface ivf_resp_if;
  logic        fault;
  logic [7:0]  action;
  logic        clear;
  logic [15:0] unit_cycles;
  logic        run;
  logic        latched;

  modport resp (input fault, input action, input clear, input unit_cycles, output run, output latched);
  modport ctrl (output fault, output action, output clear, output unit_cycles, input run, input latched);
endinterface

// >>> ivf_supervisor.sv
// Input voltage fault supervisor: management link slave, limit registers,
// comparators and two fault responders that gate the power stage.
// Assumes vin samples, neighbouring settings and fault_clear come from clk logic;
// the management link pins are asynchronous and open drain.
//
// Functional notes
// R1: Response 00 keeps regulating without interruption while the fault persists.
// R2: Response 01 runs for the delay, then applies retry setting if fault remains.
// R3: Response 10 disables output at once, then follows the retry setting.
// R4: Response 11 holds output off while fault persists, resumes when it clears.
// R5: Retry zero means no restart; output stays off until fault is cleared.
// R6: Delay code n gives two to the power n time units, up to 128.
// R7: Delay serves as run time after fault or spacing between restart attempts.
// R8: One delay unit's length comes from the separate time-unit setting.
// R9: Sixteen-bit linear over-voltage warning threshold compared against input voltage.
// R10: Under-voltage warning threshold also switches the ratio regulation mode.
// R11: Ratio regulation only acts when the vendor option flag enables it.
// R12: Sixteen-bit linear under-voltage fault threshold detects under-voltage faults.
// R13: Separate eight-bit over- and under-voltage fault actions with same layout.
// R14: Warning and fault crossings raise event pulses for the host.
// R15: Nonzero retry counts give bounded restarts spaced by delay, then latch off.
module ivf_supervisor (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Management link pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Input voltage sample, linear format
  input  wire logic [15:0] vin_sample,
  input  wire logic        vin_sample_valid,
  // Neighbouring settings
  input  wire logic [15:0] ov_fault_limit,
  input  wire logic [15:0] delay_unit_cycles,
  input  wire logic [7:0]  vendor_option_flags,
  input  wire logic        fault_clear,
  // Power stage and status
  output logic             output_enable,
  output logic             ratio_regulation_mode,
  output logic [5:0]       vin_status,
  output logic             ov_warn_event,
  output logic             uv_warn_event,
  output logic             ov_fault_event,
  output logic             uv_fault_event
);
  // Registers
  logic [7:0]  ov_action;
  logic [7:0]  uv_action;
  logic [15:0] ov_warn_thresh;
  logic [15:0] uv_warn_thresh;
  logic [15:0] uv_fault_thresh;

  // Link engine state
  ivf_pkg::ivf_smb_state_t smb_state;
  ivf_pkg::ivf_smb_state_t next_smb_state;
  logic       scl_s;
  logic       sda_s;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [2:0] byte_cnt;
  logic [2:0] next_byte_cnt;
  logic       rw;
  logic       next_rw;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [7:0] low_byte;
  logic [7:0] next_low_byte;
  logic [7:0] tx_shift;
  logic [7:0] next_tx_shift;
  logic [1:0] tx_count;
  logic [1:0] next_tx_count;
  logic       next_sda_oe;

  ivf_resp_if ov_if ();
  ivf_resp_if uv_if ();

  ivf_sync2 u_sync_scl (
    .clk      (clk),
    .rst      (rst),
    .async_in (scl_in),
    .sync_out (scl_s)
  );

  ivf_sync2 u_sync_sda (
    .clk      (clk),
    .rst      (rst),
    .async_in (sda_in),
    .sync_out (sda_s)
  );

  // Bus conditions, seen only through the synchronised copies
  wire logic start_cond = scl_s && scl_q && sda_q && !sda_s;
  wire logic stop_cond  = scl_s && scl_q && !sda_q && sda_s;
  wire logic scl_rise   = scl_s && !scl_q;
  wire logic scl_fall   = !scl_s && scl_q;

  wire logic [1:0] cmd_width  = ivf_pkg::ivf_cmd_width(cmd);
  wire logic [1:0] rx_width   = ivf_pkg::ivf_cmd_width(shift);
  wire logic       byte_done  = (smb_state == ivf_pkg::SMB_RX) && scl_fall && (bit_cnt == 4'h8);
  wire logic       addr_match = (shift[7:1] == ivf_pkg::SLAVE_ADDR);
  wire logic       ack_ok     = (byte_cnt == 3'h0) ? addr_match :
                                (byte_cnt == 3'h1) ? (rx_width != 2'h0) :
                                (byte_cnt == 3'h2) ? (cmd_width != 2'h0) :
                                (byte_cnt == 3'h3) ? (cmd_width == 2'h2) : 1'b0;
  wire logic       wr_strobe  = byte_done && !rw && ack_ok &&
                                (((byte_cnt == 3'h2) && (cmd_width == 2'h1)) || (byte_cnt == 3'h3));
  wire logic [15:0] wr_data   = (cmd_width == 2'h1) ? {8'h00, shift} : {shift, low_byte};

  wire logic [15:0] rd_word =
    (cmd == ivf_pkg::CMD_OV_FAULT_ACTION) ? {8'h00, ov_action} :
    (cmd == ivf_pkg::CMD_UV_FAULT_ACTION) ? {8'h00, uv_action} :
    (cmd == ivf_pkg::CMD_OV_WARN_THRESH)  ? ov_warn_thresh :
    (cmd == ivf_pkg::CMD_UV_WARN_THRESH)  ? uv_warn_thresh :
    (cmd == ivf_pkg::CMD_UV_FAULT_THRESH) ? uv_fault_thresh : 16'hffff;
  // Words go low byte first; anything past the data reads as released bus
  wire logic [7:0] tx_next_byte = (tx_count == 2'h0) ? rd_word[7:0] :
                                  ((tx_count == 2'h1) && (cmd_width == 2'h2)) ? rd_word[15:8] : 8'hff;

  always_comb begin
    next_smb_state = smb_state;
    next_shift     = shift;
    next_bit_cnt   = bit_cnt;
    next_byte_cnt  = byte_cnt;
    next_rw        = rw;
    next_cmd       = cmd;
    next_low_byte  = low_byte;
    next_tx_shift  = tx_shift;
    next_tx_count  = tx_count;
    next_sda_oe    = sda_oe;
    if (start_cond) begin
      next_smb_state = ivf_pkg::SMB_RX;
      next_bit_cnt   = 4'h0;
      next_byte_cnt  = 3'h0;
      next_tx_count  = 2'h0;
      next_sda_oe    = 1'b0;
    end else if (stop_cond) begin
      next_smb_state = ivf_pkg::SMB_IDLE;
      next_sda_oe    = 1'b0;
    end else begin
      case (smb_state)
        ivf_pkg::SMB_IDLE: next_sda_oe = 1'b0;
        ivf_pkg::SMB_RX: begin
          if (scl_rise) begin
            next_shift   = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (byte_done) begin
            if (byte_cnt != 3'h7) begin
              next_byte_cnt = byte_cnt + 3'h1;
            end
            if (byte_cnt == 3'h0) begin
              next_rw = shift[0];
            end
            if ((byte_cnt == 3'h1) && !rw) begin
              next_cmd = shift;
            end
            if (byte_cnt == 3'h2) begin
              next_low_byte = shift;
            end
            // Refusing a byte leaves the line released so the master sees a nack
            next_sda_oe    = ack_ok;
            next_smb_state = ack_ok ? ivf_pkg::SMB_RACK : ivf_pkg::SMB_IDLE;
          end
        end
        ivf_pkg::SMB_RACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_tx_shift  = tx_next_byte;
              next_tx_count  = 2'h1;
              next_sda_oe    = !tx_next_byte[7];
              next_bit_cnt   = 4'h1;
              next_smb_state = ivf_pkg::SMB_TX;
            end else begin
              next_sda_oe    = 1'b0;
              next_bit_cnt   = 4'h0;
              next_smb_state = ivf_pkg::SMB_RX;
            end
          end
        end
        ivf_pkg::SMB_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              next_sda_oe    = 1'b0;
              next_smb_state = ivf_pkg::SMB_TACK;
            end else begin
              next_sda_oe   = !tx_shift[6];
              next_tx_shift = {tx_shift[6:0], 1'b0};
              next_bit_cnt  = bit_cnt + 4'h1;
            end
          end
        end
        ivf_pkg::SMB_TACK: begin
          if (scl_rise) begin
            next_smb_state = sda_s ? ivf_pkg::SMB_IDLE : ivf_pkg::SMB_TNEXT;
          end
        end
        ivf_pkg::SMB_TNEXT: begin
          if (scl_fall) begin
            next_tx_shift  = tx_next_byte;
            next_tx_count  = (tx_count == 2'h3) ? tx_count : tx_count + 2'h1;
            next_sda_oe    = !tx_next_byte[7];
            next_bit_cnt   = 4'h1;
            next_smb_state = ivf_pkg::SMB_TX;
          end
        end
        default: next_smb_state = ivf_pkg::SMB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      smb_state <= ivf_pkg::SMB_IDLE;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      shift     <= 8'h00;
      bit_cnt   <= 4'h0;
      byte_cnt  <= 3'h0;
      rw        <= 1'b0;
      cmd       <= 8'h00;
      low_byte  <= 8'h00;
      tx_shift  <= 8'h00;
      tx_count  <= 2'h0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
    end else begin
      smb_state <= next_smb_state;
      scl_q     <= scl_s;
      sda_q     <= sda_s;
      shift     <= next_shift;
      bit_cnt   <= next_bit_cnt;
      byte_cnt  <= next_byte_cnt;
      rw        <= next_rw;
      cmd       <= next_cmd;
      low_byte  <= next_low_byte;
      tx_shift  <= next_tx_shift;
      tx_count  <= next_tx_count;
      sda_oe    <= next_sda_oe;
      sda_out   <= 1'b0;
    end
  end

  // Register file, written when the last data byte of a command is acked
  always_ff @(posedge clk) begin
    if (rst) begin
      ov_action       <= ivf_pkg::RST_OV_FAULT_ACTION;
      uv_action       <= ivf_pkg::RST_UV_FAULT_ACTION;
      ov_warn_thresh  <= ivf_pkg::RST_OV_WARN_THRESH;
      uv_warn_thresh  <= ivf_pkg::RST_UV_WARN_THRESH;
      uv_fault_thresh <= ivf_pkg::RST_UV_FAULT_THRESH;
    end else if (wr_strobe) begin
      case (cmd)
        ivf_pkg::CMD_OV_FAULT_ACTION: ov_action       <= wr_data[7:0]; // R13
        ivf_pkg::CMD_UV_FAULT_ACTION: uv_action       <= wr_data[7:0]; // R13
        ivf_pkg::CMD_OV_WARN_THRESH:  ov_warn_thresh  <= wr_data; // R9
        ivf_pkg::CMD_UV_WARN_THRESH:  uv_warn_thresh  <= wr_data; // R10
        ivf_pkg::CMD_UV_FAULT_THRESH: uv_fault_thresh <= wr_data; // R12
        default: ;
      endcase
    end
  end

  // Comparators work on the decoded linear values, not on raw codes
  wire logic signed [42:0] vin_val    = ivf_pkg::ivf_lin_value(vin_sample);
  wire logic               ov_warn_c  = vin_val > ivf_pkg::ivf_lin_value(ov_warn_thresh); // R9
  wire logic               uv_warn_c  = vin_val < ivf_pkg::ivf_lin_value(uv_warn_thresh);
  wire logic               ov_fault_c = vin_val > ivf_pkg::ivf_lin_value(ov_fault_limit);
  wire logic               uv_fault_c = vin_val < ivf_pkg::ivf_lin_value(uv_fault_thresh); // R12
  wire logic               ratio_c    = vendor_option_flags[ivf_pkg::VOPT_RATIO_BIT] && !uv_warn_c; // R11

  assign ov_if.fault       = vin_status[ivf_pkg::STAT_OV_FAULT];
  assign ov_if.action      = ov_action;
  assign ov_if.clear       = fault_clear;
  assign ov_if.unit_cycles = delay_unit_cycles; // R8
  assign uv_if.fault       = vin_status[ivf_pkg::STAT_UV_FAULT];
  assign uv_if.action      = uv_action;
  assign uv_if.clear       = fault_clear;
  assign uv_if.unit_cycles = delay_unit_cycles; // R8

  ivf_fault_responder u_ov_resp (
    .clk  (clk),
    .rst  (rst),
    .port (ov_if.resp)
  );

  ivf_fault_responder u_uv_resp (
    .clk  (clk),
    .rst  (rst),
    .port (uv_if.resp)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      vin_status            <= 6'h00;
      output_enable         <= 1'b0;
      ratio_regulation_mode <= 1'b0;
      ov_warn_event         <= 1'b0;
      uv_warn_event         <= 1'b0;
      ov_fault_event        <= 1'b0;
      uv_fault_event        <= 1'b0;
    end else begin
      ov_warn_event  <= vin_sample_valid && ov_warn_c && !vin_status[ivf_pkg::STAT_OV_WARN]; // R14
      uv_warn_event  <= vin_sample_valid && uv_warn_c && !vin_status[ivf_pkg::STAT_UV_WARN]; // R14
      ov_fault_event <= vin_sample_valid && ov_fault_c && !vin_status[ivf_pkg::STAT_OV_FAULT]; // R14
      uv_fault_event <= vin_sample_valid && uv_fault_c && !vin_status[ivf_pkg::STAT_UV_FAULT]; // R14
      // Dropping the enable stops the mode at once; it only starts again on a fresh sample
      ratio_regulation_mode <= vin_sample_valid ? ratio_c :
                               (ratio_regulation_mode && vendor_option_flags[ivf_pkg::VOPT_RATIO_BIT]); // R10 R11
      vin_status[5:4]       <= {uv_if.latched, ov_if.latched}; // R5
      output_enable         <= ov_if.run && uv_if.run;
      if (vin_sample_valid) begin
        vin_status[3:0] <= {uv_fault_c, ov_fault_c, uv_warn_c, ov_warn_c};
      end
    end
  end
endmodule

// >>> ivf_supervisor_props.sv
// Port-level assertions for the input voltage fault supervisor.
// Assumes one clk domain with synchronous active-high rst.
module ivf_supervisor_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Watched ports
  input wire logic       vin_sample_valid,
  input wire logic [7:0] vendor_option_flags,
  input wire logic       fault_clear,
  input wire logic       output_enable,
  input wire logic       ratio_regulation_mode,
  input wire logic [5:0] vin_status,
  input wire logic       ov_warn_event,
  input wire logic       uv_warn_event,
  input wire logic       ov_fault_event,
  input wire logic       uv_fault_event
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [3:0] clr_hist;
  // Clear reaches the latch flags through a short pipeline
  always_ff @(posedge clk) clr_hist <= rst ? 4'h0 : {clr_hist[2:0], fault_clear};
  sequence s_flag_off; !vendor_option_flags[0] [*3]; endsequence
  sequence s_was_fault; |$past(vin_status[3:2], 2); endsequence
  property p_ovw; ov_warn_event == $rose(vin_status[0]); endproperty
  a_ovw: assert property (p_ovw) else $error("ov warn event");
  property p_uvw; uv_warn_event == $rose(vin_status[1]); endproperty
  a_uvw: assert property (p_uvw) else $error("uv warn event");
  property p_ovf; ov_fault_event == $rose(vin_status[2]); endproperty
  a_ovf: assert property (p_ovf) else $error("ov fault event");
  property p_uvf; uv_fault_event == $rose(vin_status[3]); endproperty
  a_uvf: assert property (p_uvf) else $error("uv fault event");
  property p_stat; $changed(vin_status[3:0]) |-> $past(vin_sample_valid) || $past(vin_sample_valid, 2); endproperty
  a_stat: assert property (p_stat) else $error("status moved");
  property p_ratio; s_flag_off |-> !ratio_regulation_mode; endproperty
  a_ratio: assert property (p_ratio) else $error("ratio on");
  property p_off; $fell(output_enable) |-> s_was_fault; endproperty
  a_off: assert property (p_off) else $error("off without fault");
  property p_latch; vin_status[4] && $past(vin_status[4], 2) |-> !output_enable; endproperty
  a_latch: assert property (p_latch) else $error("latched but on");
  property p_free; $fell(vin_status[4]) |-> |clr_hist; endproperty
  a_free: assert property (p_free) else $error("latch freed");
endmodule
bind ivf_supervisor ivf_supervisor_props chk (.clk(clk), .rst(rst), .vin_sample_valid(vin_sample_valid),
  .vendor_option_flags(vendor_option_flags), .fault_clear(fault_clear), .output_enable(output_enable),
  .ratio_regulation_mode(ratio_regulation_mode), .vin_status(vin_status), .ov_warn_event(ov_warn_event),
  .uv_warn_event(uv_warn_event),
  .ov_fault_event(ov_fault_event), .uv_fault_event(uv_fault_event));

// >>> ivf_supervisor_tb.sv
// Self-checking bench for the input voltage fault supervisor.
// Assumes the host model on an open-drain link with a pull-up.
module ivf_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        vld = 1'b0;
  logic        clr = 1'b0;
  logic [15:0] vin = 16'h0000;
  logic [7:0]  flags = 8'h01;
  logic        scl, sda_low, sda_out, sda_oe, oe, ratio, prev;
  logic [5:0]  stat;
  int          mismatches = 0;
  int          n_checks = 0;
  int          rises;
  wire         sda = !(sda_low || (sda_oe && !sda_out));
  // Rows: vin sample, expected status[3:0], expected ratio mode
  localparam logic [20:0] ROWS [5] = '{{16'h0032, 4'h0, 1'h1}, {16'h006e, 4'h1, 1'h1},
    {16'h0023, 4'h2, 1'h0}, {16'h0080, 4'h5, 1'h1}, {16'h0014, 4'ha, 1'h0}};
  always #12.5 clk = !clk;
  ivf_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));
  ivf_supervisor DUT (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .vin_sample(vin), .vin_sample_valid(vld), .ov_fault_limit(16'h0078), .delay_unit_cycles(16'h0003),
    .vendor_option_flags(flags), .fault_clear(clr), .output_enable(oe), .ratio_regulation_mode(ratio),
    .vin_status(stat), .ov_warn_event(), .uv_warn_event(), .ov_fault_event(), .uv_fault_event());
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic sample(input logic [15:0] v);
    @(negedge clk);
    vin = v;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v, input int n, input logic e);
    @(negedge clk);
    host.write(c, v, n);
    check(host.ack, e);
  endtask
  task automatic clear;
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
  endtask
  task automatic wait_oe(input logic e, input int lim);
    int i;
    for (i = 0; i < lim && oe !== e; i++) @(negedge clk);
    check(oe, e);
    if (oe !== e) close_out();
  endtask
  initial begin
    cyc(20);
    check(oe, 1'b0);
    rst = 1'b0;
    cyc(3);
    check(oe, 1'b1);
    wr(8'h56, 16'h0000, 1, 1'b1);
    wr(8'h5a, 16'h0000, 1, 1'b1);
    wr(8'h57, 16'h0064, 2, 1'b1);
    wr(8'h58, 16'h0028, 2, 1'b1);
    wr(8'h59, 16'h001e, 2, 1'b1);
    wr(8'h5b, 16'h0000, 1, 1'b0);
    $display("setup done");
    foreach (ROWS[i]) begin
      sample(ROWS[i][20:5]);
      cyc(3);
      check(stat[3:0], ROWS[i][4:1]);
      check(ratio, ROWS[i][0]);
      check(oe, 1'b1);
    end
    sample(16'h0032);
    cyc(3);
    check(ratio, 1'b1);
    flags = 8'h00;
    cyc(3);
    check(ratio, 1'b0);
    sample(16'h0032);
    cyc(3);
    check(ratio, 1'b0);
    $display("table done");
    wr(8'h56, 16'h0080, 1, 1'b1);
    sample(16'h0080);
    cyc(3);
    check(oe, 1'b0);
    sample(16'h0032);
    cyc(20);
    check(stat[4], 1'b1);
    clear();
    wait_oe(1'b1, 8);
    $display("latch test done");
    wr(8'h56, 16'h0041, 1, 1'b1);
    sample(16'h0080);
    sample(16'h0032);
    cyc(20);
    check(oe, 1'b1);
    sample(16'h0080);
    cyc(6);
    check(oe, 1'b1);
    wait_oe(1'b0, 6);
    sample(16'h0032);
    clear();
    wait_oe(1'b1, 8);
    $display("delay test done");
    wr(8'h56, 16'h0088, 1, 1'b1);
    rises = 0;
    prev = oe;
    sample(16'h0080);
    repeat (60) begin
      @(negedge clk);
      rises += int'(oe && !prev);
      prev = oe;
    end
    check(16'(rises), 16'h0001);
    check(stat[4], 1'b1);
    sample(16'h0032);
    clear();
    wait_oe(1'b1, 8);
    $display("retry test done");
    wr(8'h5a, 16'h00c0, 1, 1'b1);
    sample(16'h0014);
    cyc(13);
    check(oe, 1'b0);
    sample(16'h0032);
    wait_oe(1'b1, 6);
    check(stat[5], 1'b0);
    $display("resume test done");
    close_out();
  end
endmodule

// >>> ivf_sync2.sv
// Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes the input changes slowly compared with clk.
module ivf_sync2 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta     <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> ivf_top_note_placeholder.sv
// Intentionally empty compilation unit kept out; see supervisor.
